// ### bus_master_model.sv
`timescale 1ns/1ps
module bus_master_model (
    input logic core_clk,
    output logic m_oe
);
    initial m_oe = 1'b0;
    // Reset pulse comfortably past the shortened 4000-cycle threshold
    task automatic bus_reset();
        @(posedge core_clk);
        m_oe <= 1'b1;
        repeat (4100) @(posedge core_clk);
        m_oe <= 1'b0;
    endtask : bus_reset
    // Write-0 holds past the sample point, write-1 lets go early; 3010-cycle slots keep the run short
    task automatic send_bit(input logic b);
        m_oe <= 1'b1;
        repeat (b ? 100 : 3006) @(posedge core_clk);
        m_oe <= 1'b0;
        repeat (b ? 2910 : 4) @(posedge core_clk);
    endtask : send_bit
    task automatic send_byte(input logic [7:0] v);
        for (int i = 0; i < 8; i++) send_bit(v[i]);
    endtask : send_byte
endmodule : bus_master_model

// ### line_slot_timer.sv
`timescale 1ns/1ps
`include "single_wire_consts.svh"

module line_slot_timer #(
    parameter int RESET_LOW_CYC = `RESET_LOW_CYC,
    parameter int PRES_LOW_CYC = `PRES_LOW_CYC
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic dq_in,
    input wire logic tx_en,
    input wire logic tx_bit,
    output logic slot_fall,
    output logic slot_sample,
    output logic sample_bit,
    output logic line_rise,
    output logic bus_reset,
    output logic dq_out,
    output logic dq_oe
);
    localparam int CNT_W = 16;
    localparam int SAMPLE_CYC = `SLOT_SAMPLE_CYC;
    localparam int WAIT_CYC = `PRES_WAIT_CYC;

    generate
        if (RESET_LOW_CYC <= SAMPLE_CYC || RESET_LOW_CYC >= (1 << CNT_W) || PRES_LOW_CYC >= (1 << CNT_W)
            || PRES_LOW_CYC < 1) begin : g_bad_param
            $error("line_slot_timer: timing parameters out of range");
        end
    endgenerate

    logic dq_meta_r, dq_sync_r, dq_prev_r;
    logic fall, rise;
    logic [CNT_W-1:0] since_r, low_cnt_r, pres_cnt_r;
    logic slot_act_r, hold_low_r, rst_seen_r, pres_wait_r, pres_drive_r;

    // Two-stage synchroniser; only dq_sync_r and its delayed copy dq_prev_r feed logic
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            dq_meta_r <= 1'b1;
            dq_sync_r <= 1'b1;
            dq_prev_r <= 1'b1;
        end else begin
            dq_meta_r <= dq_in;
            dq_sync_r <= dq_meta_r;
            dq_prev_r <= dq_sync_r;
        end
    end

    // Our own presence pulse must not look like a master slot
    assign fall = dq_prev_r & ~dq_sync_r & ~pres_drive_r;
    assign rise = ~dq_prev_r & dq_sync_r;

    // Slot timing: sample mid-window, hold a read zero until then
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            since_r <= '0;
            slot_act_r <= 1'b0;
            hold_low_r <= 1'b0;
            slot_fall <= 1'b0;
            slot_sample <= 1'b0;
            sample_bit <= 1'b1;
            line_rise <= 1'b0;
        end else begin
            slot_fall <= fall;
            line_rise <= rise;
            slot_sample <= 1'b0;
            if (fall) begin
                since_r <= '0;
                slot_act_r <= 1'b1;
                hold_low_r <= tx_en & ~tx_bit;
            end else if (slot_act_r) begin
                since_r <= since_r + 1'b1;
                if (since_r == CNT_W'(SAMPLE_CYC - 1)) begin
                    slot_act_r <= 1'b0;
                    hold_low_r <= 1'b0;
                    slot_sample <= 1'b1;
                    sample_bit <= dq_sync_r;
                end
            end
        end
    end

    // Long low detection, then presence after the line rises
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            low_cnt_r <= '0;
            bus_reset <= 1'b0;
            rst_seen_r <= 1'b0;
            pres_wait_r <= 1'b0;
            pres_drive_r <= 1'b0;
            pres_cnt_r <= '0;
        end else begin
            bus_reset <= 1'b0;
            if (dq_sync_r || pres_drive_r) begin
                low_cnt_r <= '0;
            end else if (low_cnt_r != CNT_W'(RESET_LOW_CYC)) begin
                low_cnt_r <= low_cnt_r + 1'b1;
            end
            if (!dq_sync_r && !pres_drive_r && low_cnt_r == CNT_W'(RESET_LOW_CYC - 1)) begin
                bus_reset <= 1'b1;
                rst_seen_r <= 1'b1;
                pres_wait_r <= 1'b0;
            end else if (rst_seen_r && rise) begin
                rst_seen_r <= 1'b0;
                pres_wait_r <= 1'b1;
                pres_cnt_r <= '0;
            end else if (pres_wait_r) begin
                pres_cnt_r <= pres_cnt_r + 1'b1;
                if (pres_cnt_r == CNT_W'(WAIT_CYC - 1)) begin
                    pres_wait_r <= 1'b0;
                    pres_drive_r <= 1'b1;
                    pres_cnt_r <= '0;
                end
            end else if (pres_drive_r) begin
                pres_cnt_r <= pres_cnt_r + 1'b1;
                if (pres_cnt_r == CNT_W'(PRES_LOW_CYC - 1)) begin
                    pres_drive_r <= 1'b0;
                end
            end
        end
    end

    // Open-drain pad: data is always low, only the enable moves
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            dq_out <= 1'b0;
            dq_oe <= 1'b0;
        end else begin
            dq_out <= 1'b0;
            dq_oe <= pres_drive_r | (slot_act_r & hold_low_r & ~fall);
        end
    end

endmodule : line_slot_timer

// ### single_wire_consts.svh
`ifndef SINGLE_WIRE_CONSTS_SVH
`define SINGLE_WIRE_CONSTS_SVH

// Core clock rate
`define CORE_CLK_MHZ 100

// Line timing, in microseconds
`define RESET_LOW_US 120
`define SLOT_SAMPLE_US 30
`define PRES_WAIT_US 30
`define PRES_LOW_US 100
`define NV_COPY_TIME_US 2000

// Cycle counts derived from the times above
`define RESET_LOW_CYC (`RESET_LOW_US * `CORE_CLK_MHZ)
`define SLOT_SAMPLE_CYC (`SLOT_SAMPLE_US * `CORE_CLK_MHZ)
`define PRES_WAIT_CYC (`PRES_WAIT_US * `CORE_CLK_MHZ)
`define PRES_LOW_CYC (`PRES_LOW_US * `CORE_CLK_MHZ)
`define NV_COPY_CYC (`NV_COPY_TIME_US * `CORE_CLK_MHZ)

// Net-address command opcodes
`define OP_READ_ADDR_A 8'h33
`define OP_READ_ADDR_B 8'h39
`define OP_MATCH_ADDR 8'h55
`define OP_SKIP_ADDR 8'hcc
`define OP_SEARCH_ADDR 8'hf0
`define OP_SWAP 8'haa

// Function command opcodes
`define OP_READ_DATA 8'h69
`define OP_WRITE_DATA 8'h6c
`define OP_COPY_DATA 8'h48
`define OP_RECALL_DATA 8'hb8
`define OP_LOCK 8'h6a

// Memory map
`define MEM_ADDR_LAST 8'hff
`define NV_REGION_HI 3'h1
`define NET_ADDR_BITS 64

`endif

// ### single_wire_pkg.sv
package single_wire_pkg;

    // Transaction sequencer states, Gray coded along the usual path
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_ROMCMD = 4'h1,
        ST_FUNC = 4'h3,
        ST_FADDR = 4'h2,
        ST_READ = 4'h6,
        ST_WRITE = 4'h7,
        ST_DONE = 4'h5,
        ST_RD_ADDR = 4'h4,
        ST_MATCH = 4'hc,
        ST_SEARCH = 4'hd,
        ST_SWAP_ADDR = 4'hf,
        ST_SWAP_PULSE = 4'he
    } seq_state_t;

    // Three steps of one search bit
    typedef enum logic [1:0] {
        SRCH_TRUE = 2'h0,
        SRCH_COMPL = 2'h1,
        SRCH_CHOICE = 2'h3
    } search_phase_t;

endpackage : single_wire_pkg

// ### single_wire_slave.sv
`timescale 1ns/1ps
`include "single_wire_consts.svh"

// Operation
// - Drive the line only through an open-drain enable, never high.
// - Line idles high; low over 120 us is a reset ending the transaction.
// - Reset, presence, net-address command, function command, then data.
// - Read-address opcode is 33h or 39h per select bit; send 64 bits.
// - Match 55h: proceed only if received address equals ours, else wait.
// - Skip CCh selects the device without any address.
// - Search F0h: send bit, complement, read choice; drop out on mismatch.
// - Swap AAh: address, then pulse; fall cuts power, rise restores selected.
// - Swap opcode, address and pulse ignored unless swap enable is set.
// - Read 69h: send data LSB first after address, advance per byte.
// - Reading past FFh returns ones until reset.
// - Reset at any bit boundary abandons a read cleanly.
// - Write 6Ch: take data LSB first, advance per byte, drop past FFh.
// - Ignore writes to read-only, reserved or locked nonvolatile locations.
// - A byte cut short by reset is not stored.
// - Writes to unlocked nonvolatile blocks update shadow RAM only.
// - Copy 48h moves the 16-byte shadow block to nonvolatile unless locked.
// - During copy, busy is high and nonvolatile writes are ignored.
// - Copy starts after last address bit, lasts about 2 ms, clears busy.
// - Recall B8h loads the 16-byte nonvolatile block into shadow RAM.
// - Lock 6Ah locks the block permanently, only when lock arm is set.
// - After a lock command the lock-arm bit returns to zero.
// - Sample the line 15 to 60 us after a master falling edge.
// - Address is family byte, 48-bit serial, CRC byte; family first.
module single_wire_slave
    import single_wire_pkg::*;
#(
    parameter int RESET_LOW_CYC = `RESET_LOW_CYC,
    parameter int PRES_LOW_CYC = `PRES_LOW_CYC,
    parameter int NV_COPY_CYC = `NV_COPY_CYC
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic dq_in,
    output logic dq_out,
    output logic dq_oe,
    input wire logic [63:0] net_addr,
    input wire logic net_addr_opcode_select,
    input wire logic swap_cmd_enable,
    input wire logic lock_arm,
    output logic lock_arm_clear,
    input wire logic [1:0] lock_flags_nv,
    output logic [1:0] block_locked,
    output logic [7:0] mem_addr,
    input wire logic [7:0] mem_rd_data,
    input wire logic mem_loc_writable,
    output logic mem_wr_en,
    output logic [7:0] mem_wr_data,
    output logic nv_copy_start,
    output logic nv_recall,
    output logic nv_blk_sel,
    output logic nv_copy_busy,
    output logic swap_power_enable,
    output logic swap_sleep_req,
    output logic swap_master
);
    localparam int CP_W = $clog2(NV_COPY_CYC + 1);

    generate
        if (NV_COPY_CYC < 1) begin : g_bad_copy
            $error("single_wire_slave: copy time must be at least one cycle");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Declarations
    ////////////////////////////////////////////////////////////////////////////////////////////////

    seq_state_t state_r;
    search_phase_t phase_r;
    logic [6:0] bit_cnt_r;
    logic [7:0] rx_sh_r;
    logic [7:0] func_op_r;
    logic sel_ok_r, past_end_r, cap_done_r;
    logic [CP_W-1:0] copy_cnt_r;

    logic slot_fall, slot_sample, sample_bit, line_rise, bus_reset;
    logic tx_en, tx_bit;
    logic [7:0] rx_byte;
    logic byte_done, addr_done, my_bit, fa_done;
    logic rx_nv, rx_blk, rx_blk_locked;
    logic cur_nv, wr_ok;
    logic [7:0] read_op;

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Line front end
    ////////////////////////////////////////////////////////////////////////////////////////////////

    line_slot_timer #(
        .RESET_LOW_CYC(RESET_LOW_CYC),
        .PRES_LOW_CYC(PRES_LOW_CYC)
    ) u_slot (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .dq_in(dq_in),
        .tx_en(tx_en),
        .tx_bit(tx_bit),
        .slot_fall(slot_fall),
        .slot_sample(slot_sample),
        .sample_bit(sample_bit),
        .line_rise(line_rise),
        .bus_reset(bus_reset),
        .dq_out(dq_out),
        .dq_oe(dq_oe)
    );

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Decode helpers
    ////////////////////////////////////////////////////////////////////////////////////////////////

    // Bits arrive LSB first, so shift in from the top
    assign rx_byte = {sample_bit, rx_sh_r[7:1]};
    assign byte_done = slot_sample && (bit_cnt_r[2:0] == 3'h7);
    assign addr_done = slot_sample && (bit_cnt_r == 7'(`NET_ADDR_BITS - 1));
    assign my_bit = net_addr[bit_cnt_r[5:0]];
    assign fa_done = (state_r == ST_FADDR) && byte_done;
    assign read_op = net_addr_opcode_select ? `OP_READ_ADDR_B : `OP_READ_ADDR_A;

    // Nonvolatile region is two 16-byte blocks, selected by address bit 4
    assign rx_nv = (rx_byte[7:5] == `NV_REGION_HI);
    assign rx_blk = rx_byte[4];
    assign rx_blk_locked = block_locked[rx_blk];
    assign cur_nv = (mem_addr[7:5] == `NV_REGION_HI);
    assign wr_ok = !past_end_r && mem_loc_writable
        && !(cur_nv && (block_locked[mem_addr[4]] || nv_copy_busy));

    // Bit to present in the next read slot; released otherwise
    always_comb begin
        tx_en = 1'b0;
        tx_bit = 1'b1;
        case (state_r)
            ST_RD_ADDR: begin
                tx_en = 1'b1;
                tx_bit = my_bit;
            end
            ST_SEARCH: begin
                tx_en = (phase_r != SRCH_CHOICE);
                tx_bit = (phase_r == SRCH_TRUE) ? my_bit : ~my_bit;
            end
            ST_READ: begin
                tx_en = 1'b1;
                tx_bit = past_end_r | mem_rd_data[bit_cnt_r[2:0]];
            end
            default: begin
                tx_en = 1'b0;
                tx_bit = 1'b1;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Transaction sequencer
    ////////////////////////////////////////////////////////////////////////////////////////////////

    // A bus reset overrides everything, so a half byte is simply lost
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            phase_r <= SRCH_TRUE;
            bit_cnt_r <= '0;
            rx_sh_r <= '0;
            func_op_r <= '0;
            sel_ok_r <= 1'b1;
        end else if (bus_reset) begin
            state_r <= ST_ROMCMD;
            phase_r <= SRCH_TRUE;
            bit_cnt_r <= '0;
            sel_ok_r <= 1'b1;
        end else if (state_r == ST_SWAP_PULSE) begin
            if (line_rise) begin
                state_r <= ST_DONE;
            end
        end else if (slot_sample) begin
            rx_sh_r <= rx_byte;
            bit_cnt_r <= bit_cnt_r + 1'b1;
            case (state_r)
                ST_ROMCMD: begin
                    if (byte_done) begin
                        bit_cnt_r <= '0;
                        if (rx_byte == read_op) begin
                            state_r <= ST_RD_ADDR;
                        end else if (rx_byte == `OP_MATCH_ADDR) begin
                            state_r <= ST_MATCH;
                        end else if (rx_byte == `OP_SKIP_ADDR) begin
                            state_r <= ST_FUNC;
                        end else if (rx_byte == `OP_SEARCH_ADDR) begin
                            state_r <= ST_SEARCH;
                        end else if (rx_byte == `OP_SWAP && swap_cmd_enable) begin
                            state_r <= ST_SWAP_ADDR;
                        end else begin
                            state_r <= ST_DONE;
                        end
                    end
                end
                ST_RD_ADDR: begin
                    if (addr_done) begin
                        bit_cnt_r <= '0;
                        state_r <= ST_FUNC;
                    end
                end
                ST_MATCH, ST_SWAP_ADDR: begin
                    if (sample_bit != my_bit) begin
                        sel_ok_r <= 1'b0;
                    end
                    if (addr_done) begin
                        bit_cnt_r <= '0;
                        if (state_r == ST_SWAP_ADDR) begin
                            state_r <= ST_SWAP_PULSE;
                        end else if (sel_ok_r && sample_bit == my_bit) begin
                            state_r <= ST_FUNC;
                        end else begin
                            state_r <= ST_DONE;
                        end
                    end
                end
                ST_SEARCH: begin
                    // Count advances only after the master's choice slot
                    bit_cnt_r <= bit_cnt_r;
                    case (phase_r)
                        SRCH_TRUE: phase_r <= SRCH_COMPL;
                        SRCH_COMPL: phase_r <= SRCH_CHOICE;
                        default: begin
                            phase_r <= SRCH_TRUE;
                            bit_cnt_r <= bit_cnt_r + 1'b1;
                            if (sample_bit != my_bit) begin
                                state_r <= ST_DONE;
                            end else if (bit_cnt_r == 7'(`NET_ADDR_BITS - 1)) begin
                                bit_cnt_r <= '0;
                                state_r <= ST_FUNC;
                            end
                        end
                    endcase
                end
                ST_FUNC: begin
                    if (byte_done) begin
                        bit_cnt_r <= '0;
                        func_op_r <= rx_byte;
                        case (rx_byte)
                            `OP_READ_DATA, `OP_WRITE_DATA, `OP_COPY_DATA, `OP_RECALL_DATA, `OP_LOCK:
                                state_r <= ST_FADDR;
                            default: state_r <= ST_DONE;
                        endcase
                    end
                end
                ST_FADDR: begin
                    if (byte_done) begin
                        bit_cnt_r <= '0;
                        if (func_op_r == `OP_READ_DATA) begin
                            state_r <= ST_READ;
                        end else if (func_op_r == `OP_WRITE_DATA) begin
                            state_r <= ST_WRITE;
                        end else begin
                            state_r <= ST_DONE;
                        end
                    end
                end
                ST_READ, ST_WRITE: begin
                    bit_cnt_r <= {4'h0, bit_cnt_r[2:0] + 3'h1};
                end
                default: begin
                    bit_cnt_r <= '0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Memory address, write strobe
    ////////////////////////////////////////////////////////////////////////////////////////////////

    // Address wraps are refused: past FFh a read idles on ones and a write stores nothing
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_addr <= '0;
            past_end_r <= 1'b0;
            mem_wr_en <= 1'b0;
            mem_wr_data <= '0;
        end else begin
            mem_wr_en <= 1'b0;
            if (bus_reset) begin
                past_end_r <= 1'b0;
            end else if (fa_done) begin
                mem_addr <= rx_byte;
                past_end_r <= 1'b0;
            end else if ((state_r == ST_READ || state_r == ST_WRITE) && byte_done && !past_end_r) begin
                if (state_r == ST_WRITE && wr_ok) begin
                    mem_wr_en <= 1'b1;
                    mem_wr_data <= rx_byte;
                end
                if (mem_addr == `MEM_ADDR_LAST) begin
                    past_end_r <= 1'b1;
                end else begin
                    mem_addr <= mem_addr + 8'h01;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Copy, recall and lock
    ////////////////////////////////////////////////////////////////////////////////////////////////

    // Lock flags are reloaded from the nonvolatile image once after reset
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cap_done_r <= 1'b0;
            block_locked <= '0;
            lock_arm_clear <= 1'b0;
        end else begin
            lock_arm_clear <= 1'b0;
            if (!cap_done_r) begin
                cap_done_r <= 1'b1;
                block_locked <= lock_flags_nv;
            end else if (fa_done && func_op_r == `OP_LOCK && lock_arm) begin
                lock_arm_clear <= 1'b1;
                if (rx_nv) begin
                    block_locked[rx_blk] <= 1'b1;
                end
            end
        end
    end

    // Copy timer; a recall during a copy is refused to keep the shadow stable
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            nv_copy_busy <= 1'b0;
            copy_cnt_r <= '0;
            nv_copy_start <= 1'b0;
            nv_recall <= 1'b0;
            nv_blk_sel <= 1'b0;
        end else begin
            nv_copy_start <= 1'b0;
            nv_recall <= 1'b0;
            if (nv_copy_busy) begin
                copy_cnt_r <= copy_cnt_r + 1'b1;
                if (copy_cnt_r == CP_W'(NV_COPY_CYC - 1)) begin
                    nv_copy_busy <= 1'b0;
                end
            end else if (fa_done && rx_nv && func_op_r == `OP_COPY_DATA && !rx_blk_locked) begin
                nv_copy_busy <= 1'b1;
                copy_cnt_r <= '0;
                nv_copy_start <= 1'b1;
                nv_blk_sel <= rx_blk;
            end else if (fa_done && rx_nv && func_op_r == `OP_RECALL_DATA) begin
                nv_recall <= 1'b1;
                nv_blk_sel <= rx_blk;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Swap power handover
    ////////////////////////////////////////////////////////////////////////////////////////////////

    // Break before make: every enabled device drops power on the fall
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            swap_power_enable <= 1'b1;
            swap_sleep_req <= 1'b0;
            swap_master <= 1'b0;
        end else if (state_r == ST_SWAP_PULSE) begin
            if (slot_fall) begin
                swap_power_enable <= 1'b0;
            end else if (line_rise) begin
                if (sel_ok_r) begin
                    swap_power_enable <= 1'b1;
                    swap_master <= 1'b1;
                    swap_sleep_req <= 1'b0;
                end else begin
                    swap_master <= 1'b0;
                    swap_sleep_req <= 1'b1;
                end
            end
        end
    end

endmodule : single_wire_slave

// ### single_wire_slave_monitor.sv
`timescale 1ns/1ps
module slave_monitor #(parameter int NV_COPY_CYC = 50) (
    input logic core_clk,
    input logic rst_n,
    input logic dq_out,
    input logic dq_oe,
    input logic mem_wr_en,
    input logic nv_copy_start,
    input logic nv_copy_busy,
    input logic nv_blk_sel,
    input logic [1:0] block_locked,
    input logic lock_arm,
    input logic lock_arm_clear,
    input logic swap_cmd_enable,
    input logic swap_power_enable
);
    int busy_cyc_r;
    int oe_cyc_r;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // Run lengths; a stuck drive could look like a bus reset to others
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_cyc_r <= 0;
            oe_cyc_r <= 0;
        end else begin
            busy_cyc_r <= nv_copy_busy ? busy_cyc_r + 1 : 0;
            oe_cyc_r <= dq_oe ? oe_cyc_r + 1 : 0;
        end
    end
    sequence copy_go_s;
        nv_copy_start ##1 (nv_copy_busy && !nv_copy_start);
    endsequence
    ////////////////////////////////////////////////////////////////
    out_low_a: assert property (dq_out == 1'b0) else $error("pad data not low");
    oe_bound_a: assert property (oe_cyc_r <= 3100) else $error("line held too long");
    wr_pulse_a: assert property (mem_wr_en |=> !mem_wr_en) else $error("store not a pulse");
    copy_busy_a: assert property (nv_copy_start |-> copy_go_s) else $error("copy without busy");
    copy_lock_a: assert property (nv_copy_start |=> !block_locked[nv_blk_sel]) else $error("locked copy");
    copy_idle_a: assert property (nv_copy_start |-> !$past(nv_copy_busy)) else $error("copy while busy");
    busy_len_a: assert property (busy_cyc_r <= NV_COPY_CYC + 1) else $error("busy too long");
    lock_arm_a: assert property (lock_arm_clear |-> $past(lock_arm)) else $error("unarmed lock");
    lock_keep_a: assert property (!$fell(block_locked[0]) && !$fell(block_locked[1])) else $error("unlocked");
    swap_off_a: assert property (!swap_cmd_enable |-> swap_power_enable) else $error("swap acted");
endmodule : slave_monitor
bind single_wire_slave slave_monitor #(.NV_COPY_CYC(NV_COPY_CYC)) mon_i (.*);

// ### testbench.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
    $display("[FAIL] %s exp %h got %h", n, e, g); end end
module testbench;
    localparam logic [63:0] OWN_ADDR = 64'h5a5a_0123_4567_8916; // Arbitrary address
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic lock_arm = 1'b0;
    logic op_sel = 1'b0;
    logic swap_en = 1'b0;
    logic m_oe, dq_oe, dq_out, mem_wr_en, nv_copy_busy, arm_clr, copy_go, blk_sel, pwr_en;
    logic [7:0] mem_addr, mem_wr_data, wr_last;
    logic [1:0] block_locked;
    int fail_count = 0, checks_done = 0, wr_cnt = 0;
    // Pull-up: line is low whenever any party enables its drive
    wire dq_line = ~(dq_oe | m_oe);
    initial forever #5 core_clk = ~core_clk;
    // Single slave on the line, so read-address answers never collide
    bus_master_model M (.core_clk(core_clk), .m_oe(m_oe));
    // Reset threshold must exceed the fixed 3000-cycle sample point
    single_wire_slave #(.RESET_LOW_CYC(4000), .PRES_LOW_CYC(200), .NV_COPY_CYC(50)) DUT (
        .core_clk(core_clk), .rst_n(rst_n), .dq_in(dq_line), .dq_out(dq_out), .dq_oe(dq_oe), .net_addr(OWN_ADDR),
        .net_addr_opcode_select(op_sel), .swap_cmd_enable(swap_en), .lock_arm(lock_arm), .lock_arm_clear(arm_clr),
        .lock_flags_nv(2'b10), .block_locked(block_locked), .mem_addr(mem_addr), .mem_rd_data(~mem_addr),
        .mem_loc_writable(~mem_addr[7]), .mem_wr_en(mem_wr_en), .mem_wr_data(mem_wr_data), .nv_copy_start(copy_go),
        .nv_recall(), .nv_blk_sel(blk_sel), .nv_copy_busy(nv_copy_busy), .swap_power_enable(pwr_en),
        .swap_sleep_req(), .swap_master());
    // Log every store the slave issues
    always @(posedge core_clk) if (mem_wr_en) begin
        wr_cnt++;
        wr_last = mem_wr_data;
    end
    ////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : test_done
    // Skip, write one byte, then cut the next byte short with a reset
    initial begin
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge core_clk);
        `CHK("lock image", 2'b10, block_locked)
        M.bus_reset();
        repeat (3100) @(posedge core_clk);
        `CHK("presence", 1'b1, dq_oe)
        for (int i = 0; i < 400 && dq_oe !== 1'b0; i++) @(posedge core_clk);
        `CHK("presence end", 1'b0, dq_oe)
        M.send_byte(8'hcc);
        M.send_byte(8'h6c);
        M.send_byte(8'h20);
        `CHK("start addr", 8'h20, mem_addr)
        M.send_byte(8'ha5);
        `CHK("store count", 1, wr_cnt)
        `CHK("store data", 8'ha5, wr_last)
        `CHK("next addr", 8'h21, mem_addr)
        M.send_bit(1'b0);
        M.bus_reset();
        repeat (20) @(posedge core_clk);
        `CHK("partial byte", 1, wr_cnt)
        `CHK("copy idle", 1'b0, nv_copy_busy)
        `CHK("pad data", 1'b0, dq_out)
        `CHK("power kept", 1'b1, pwr_en)
        `CHK("arm kept", 1'b0, arm_clr)
        test_done();
    end
    // Watchdog: the sequence needs about 111000 cycles
    initial begin
        repeat (150000) @(posedge core_clk);
        fail_count++;
        test_done();
    end
endmodule : testbench
